/* include/fpt_pkg.sv */
// package: register map, field positions and widths of the fast pwm timer
package fpt_pkg;
   // ************
   // widths
   // ************
   localparam int CNT_W = 10;
   localparam int STAGE_W = 2;
   localparam int LOW_W = 8;
   localparam int CS_W = 4;
   localparam int PRE_W = 14;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int UNITS = 4;
   localparam int FLAG_N = 4;
   localparam int IRQ_N = 5;
   // ************
   // compare unit indices and internal flag indices
   // ************
   localparam int UNIT_A = 0;
   localparam int UNIT_B = 1;
   localparam int UNIT_TOP = 2;
   localparam int UNIT_D = 3;
   localparam int FL_OVF = 0;
   localparam int FL_A = 1;
   localparam int FL_B = 2;
   localparam int FL_D = 3;
   localparam int IRQ_FAULT = 4;
   // ************
   // register byte addresses
   // ************
   localparam logic [7:0] ADDR_COUNTER = 8'h00;
   localparam logic [7:0] ADDR_CMP_A = 8'h04;
   localparam logic [7:0] ADDR_CMP_B = 8'h08;
   localparam logic [7:0] ADDR_CMP_TOP = 8'h0C;
   localparam logic [7:0] ADDR_CMP_D = 8'h10;
   localparam logic [7:0] ADDR_STAGE = 8'h14;
   localparam logic [7:0] ADDR_CTRL_B = 8'h18;
   localparam logic [7:0] ADDR_CTRL_D = 8'h1C;
   localparam logic [7:0] ADDR_FLAGS = 8'h20;
   localparam logic [7:0] ADDR_MASK = 8'h24;
   localparam logic [7:0] ADDR_PLL = 8'h28;
   // ************
   // field positions
   // ************
   localparam int CS_LSB = 0;
   localparam int PSR_BIT = 6;
   localparam int FAULT_EN_BIT = 7;
   localparam int FAULT_FLAG_BIT = 6;
   localparam int TF_D_BIT = 7;
   localparam int TF_A_BIT = 6;
   localparam int TF_B_BIT = 5;
   localparam int TF_OVF_BIT = 2;
   localparam int SLOW_BIT = 7;
   localparam int ASYNC_BIT = 2;
   // ************
   // reset values and special counts
   // ************
   localparam logic [9:0] CNT_RST = 10'h000;
   localparam logic [9:0] TOP_RST = 10'h3FF;
   localparam logic [7:0] MAX8 = 8'hFF;
   localparam logic [3:0] CS_STOP = 4'h0;
   localparam logic [13:0] PRE_ONE = 14'h0001;
   localparam logic [9:0] CNT_ONE = 10'h001;
endpackage : fpt_pkg

/* src/fpt_compare_unit.sv */
// one compare unit: match pulse and output pin
`timescale 1ns/1ps
`default_nettype none
module fpt_compare_unit
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic timerTick,
   input wire logic matchBlock,
   input wire logic [fpt_pkg::CNT_W-1:0] count,
   input wire logic [fpt_pkg::CNT_W-1:0] compareValue,
   output logic matchPulse,
   output logic pinOut
);
   typedef struct packed {
      logic match;
      logic pin;
   } cmp_state_t;

   cmp_state_t st;
   cmp_state_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.match = 1'b0;
      if (timerTick && !matchBlock)
      begin
         if (count == compareValue)
         begin
            next_st.match = 1'b1;
            next_st.pin = 1'b0;
         end
         else if (count == fpt_pkg::CNT_RST)
         begin
            next_st.pin = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st <= '0;
      end
      else if (clkEn)
      begin
         st <= next_st;
      end
   end

   assign matchPulse = st.match;
   assign pinOut = st.pin;
endmodule : fpt_compare_unit
`default_nettype wire

/* src/fpt_prescaler.sv */
// prescaler: base clock choice, low speed halving, divide selection
`timescale 1ns/1ps
`default_nettype none
module fpt_prescaler
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic asyncMode,
   input wire logic lowSpeed,
   input wire logic fastTick,
   input wire logic [fpt_pkg::CS_W-1:0] clkSel,
   input wire logic prescalerReset,
   output logic timerTick
);
   typedef struct packed {
      logic [fpt_pkg::PRE_W-1:0] cnt;
      logic half;
      logic tick;
   } pre_state_t;

   pre_state_t st;
   pre_state_t next_st;
   logic baseTick;
   logic [fpt_pkg::PRE_W-1:0] mask;

   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      mask = '0;
      // fast clock halved in low speed
      if (fastTick && lowSpeed)
      begin
         next_st.half = ~st.half;
      end
      baseTick = asyncMode ? (fastTick && (!lowSpeed || st.half)) : 1'b1;
      if (clkSel != fpt_pkg::CS_STOP)
      begin
         mask = (fpt_pkg::PRE_ONE << (clkSel - 4'h1)) - fpt_pkg::PRE_ONE;
      end
      if (prescalerReset)
      begin
         next_st.cnt = '0;
         next_st.half = 1'b0;
      end
      else if (baseTick)
      begin
         next_st.cnt = st.cnt + fpt_pkg::PRE_ONE;
         if (clkSel != fpt_pkg::CS_STOP && (st.cnt & mask) == mask)
         begin
            next_st.tick = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st <= '0;
      end
      else if (clkEn)
      begin
         st <= next_st;
      end
   end

   assign timerTick = st.tick;
endmodule : fpt_prescaler
`default_nettype wire

/* src/fpt_timer_top.sv */
// fast pwm timer: apb registers, staging byte access, counter, sync stages
//
// Functional notes
// - fast clock 64 MHz, halved in low speed
// - 10-bit counter, 8-bit when msbs zero
// - one 2-bit staging register for all
// - low byte read copies msbs to stage
// - low byte write takes msbs from stage
// - top compare value clears the counter
// - units A, B, D drive pin and match
// - flags in flag register, individually masked
// - async compare and select writes pass sync stages first
// - control and compare read back immediately
// - counter, stage, flags read back delayed in async mode
// - prescaler base follows async select bit
// - divide 1 to 16384, plus stop
// - report bottom at zero, max whenever the counter's low byte is FF
// - prescaler reset bit resets the prescaler
// - select zero stops counting, access stays
`timescale 1ns/1ps
`default_nettype none
module fpt_timer_top
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic fastTick,
   input wire logic faultEvent,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fpt_pkg::ADDR_W-1:0] paddr,
   input wire logic [fpt_pkg::DATA_W-1:0] pwdata,
   output logic pready,
   output logic [fpt_pkg::DATA_W-1:0] prdata,
   output logic pslverr,
   output logic pwmA,
   output logic pwmB,
   output logic pwmD,
   output logic [fpt_pkg::IRQ_N-1:0] irqReq,
   output logic atBottom,
   output logic atMax
);
   // ************
   // state
   // ************
   typedef logic [fpt_pkg::UNITS-1:0][fpt_pkg::CNT_W-1:0] cmp_array_t;

   typedef struct packed {
      logic [fpt_pkg::CNT_W-1:0] counter;
      logic [fpt_pkg::STAGE_W-1:0] stage;
      cmp_array_t cmp;
      cmp_array_t cmpSync1;
      cmp_array_t cmpSync2;
      logic [fpt_pkg::CS_W-1:0] clkSel;
      logic [fpt_pkg::CS_W-1:0] clkSelSync1;
      logic [fpt_pkg::CS_W-1:0] clkSelSync2;
      logic psr;
      logic faultEn;
      logic faultFlag;
      logic [fpt_pkg::FLAG_N-1:0] flags;
      logic [fpt_pkg::FLAG_N-1:0] mask;
      logic asyncSel;
      logic lowSpeed;
      logic [fpt_pkg::CNT_W-1:0] cntRd1;
      logic [fpt_pkg::CNT_W-1:0] cntRd2;
      logic [fpt_pkg::STAGE_W-1:0] stageRd1;
      logic [fpt_pkg::STAGE_W-1:0] stageRd2;
      logic [fpt_pkg::FLAG_N-1:0] flagRd1;
      logic [fpt_pkg::FLAG_N-1:0] flagRd2;
      logic blockMatch;
      logic ready;
      logic [fpt_pkg::DATA_W-1:0] rdata;
      logic err;
      logic [fpt_pkg::IRQ_N-1:0] irq;
      logic bottom;
      logic max;
   } top_state_t;

   top_state_t st;
   top_state_t next_st;
   logic timerTick;
   logic [fpt_pkg::UNITS-1:0] matchPulse;
   logic [fpt_pkg::UNITS-1:0] unitPin;
   cmp_array_t effCmp;
   logic [fpt_pkg::CS_W-1:0] effClkSel;
   logic [fpt_pkg::CNT_W-1:0] rdCounter;
   logic [fpt_pkg::STAGE_W-1:0] rdStage;
   logic [fpt_pkg::FLAG_N-1:0] rdFlags;
   logic [fpt_pkg::LOW_W-1:0] wByte;
   logic [fpt_pkg::LOW_W-1:0] rByte;
   logic [fpt_pkg::LOW_W-1:0] flagByte;
   logic [fpt_pkg::LOW_W-1:0] maskByte;
   logic access;
   logic done;
   logic hit;
   logic isLow;
   logic [fpt_pkg::CNT_W-1:0] lowReg;
   int unitIdx;

   assign effCmp = st.asyncSel ? st.cmpSync2 : st.cmp;
   assign effClkSel = st.asyncSel ? st.clkSelSync2 : st.clkSel;
   assign rdCounter = st.asyncSel ? st.cntRd2 : st.counter;
   assign rdStage = st.asyncSel ? st.stageRd2 : st.stage;
   assign rdFlags = st.asyncSel ? st.flagRd2 : st.flags;

   // ************
   // prescaler and compare units
   // ************
   fpt_prescaler u_prescaler
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .asyncMode(st.asyncSel),
      .lowSpeed(st.lowSpeed),
      .fastTick(fastTick),
      .clkSel(effClkSel),
      .prescalerReset(st.psr),
      .timerTick(timerTick)
   );

   genvar gi;
   generate
      for (gi = 0; gi < fpt_pkg::UNITS; gi++)
      begin : g_unit
         if (gi != fpt_pkg::UNIT_TOP)
         begin : g_cmp
            fpt_compare_unit u_cmp
            (
               .core_clk(core_clk),
               .sys_rst(sys_rst),
               .clkEn(clkEn),
               .timerTick(timerTick),
               .matchBlock(st.blockMatch),
               .count(st.counter),
               .compareValue(effCmp[gi]),
               .matchPulse(matchPulse[gi]),
               .pinOut(unitPin[gi])
            );
         end
         else
         begin : g_top
            assign matchPulse[gi] = 1'b0;
            assign unitPin[gi] = 1'b0;
         end
      end
   endgenerate

   // ************
   // next state
   // ************
   always_comb
   begin
      next_st = st;
      access = psel && penable;
      done = access && st.ready;
      wByte = pwdata[fpt_pkg::LOW_W-1:0];
      flagByte = '0;
      flagByte[fpt_pkg::TF_OVF_BIT] = rdFlags[fpt_pkg::FL_OVF];
      flagByte[fpt_pkg::TF_A_BIT] = rdFlags[fpt_pkg::FL_A];
      flagByte[fpt_pkg::TF_B_BIT] = rdFlags[fpt_pkg::FL_B];
      flagByte[fpt_pkg::TF_D_BIT] = rdFlags[fpt_pkg::FL_D];
      maskByte = '0;
      maskByte[fpt_pkg::TF_OVF_BIT] = st.mask[fpt_pkg::FL_OVF];
      maskByte[fpt_pkg::TF_A_BIT] = st.mask[fpt_pkg::FL_A];
      maskByte[fpt_pkg::TF_B_BIT] = st.mask[fpt_pkg::FL_B];
      maskByte[fpt_pkg::TF_D_BIT] = st.mask[fpt_pkg::FL_D];
      // address decode
      hit = 1'b1;
      isLow = 1'b1;
      unitIdx = fpt_pkg::UNIT_A;
      lowReg = rdCounter;
      rByte = '0;
      if (paddr == fpt_pkg::ADDR_COUNTER)
      begin
         lowReg = rdCounter;
      end
      else if (paddr == fpt_pkg::ADDR_CMP_A)
      begin
         unitIdx = fpt_pkg::UNIT_A;
         lowReg = st.cmp[fpt_pkg::UNIT_A];
      end
      else if (paddr == fpt_pkg::ADDR_CMP_B)
      begin
         unitIdx = fpt_pkg::UNIT_B;
         lowReg = st.cmp[fpt_pkg::UNIT_B];
      end
      else if (paddr == fpt_pkg::ADDR_CMP_TOP)
      begin
         unitIdx = fpt_pkg::UNIT_TOP;
         lowReg = st.cmp[fpt_pkg::UNIT_TOP];
      end
      else if (paddr == fpt_pkg::ADDR_CMP_D)
      begin
         unitIdx = fpt_pkg::UNIT_D;
         lowReg = st.cmp[fpt_pkg::UNIT_D];
      end
      else
      begin
         isLow = 1'b0;
         if (paddr == fpt_pkg::ADDR_STAGE)
         begin
            rByte = {6'h00, rdStage};
         end
         else if (paddr == fpt_pkg::ADDR_CTRL_B)
         begin
            rByte = {4'h0, st.clkSel};
         end
         else if (paddr == fpt_pkg::ADDR_CTRL_D)
         begin
            rByte[fpt_pkg::FAULT_EN_BIT] = st.faultEn;
            rByte[fpt_pkg::FAULT_FLAG_BIT] = st.faultFlag;
         end
         else if (paddr == fpt_pkg::ADDR_FLAGS)
         begin
            rByte = flagByte;
         end
         else if (paddr == fpt_pkg::ADDR_MASK)
         begin
            rByte = maskByte;
         end
         else if (paddr == fpt_pkg::ADDR_PLL)
         begin
            rByte[fpt_pkg::SLOW_BIT] = st.lowSpeed;
            rByte[fpt_pkg::ASYNC_BIT] = st.asyncSel;
         end
         else
         begin
            hit = 1'b0;
         end
      end
      if (isLow)
      begin
         // compare registers read back at once
         rByte = lowReg[fpt_pkg::LOW_W-1:0];
      end
      // apb answer one cycle into the access phase
      next_st.ready = access && !st.ready;
      if (access && !st.ready)
      begin
         next_st.rdata = {24'h000000, rByte};
         next_st.err = !hit;
      end
      // sync pipelines
      next_st.cmpSync1 = st.cmp;
      next_st.cmpSync2 = st.cmpSync1;
      next_st.clkSelSync1 = st.clkSel;
      next_st.clkSelSync2 = st.clkSelSync1;
      next_st.cntRd1 = st.counter;
      next_st.cntRd2 = st.cntRd1;
      next_st.stageRd1 = st.stage;
      next_st.stageRd2 = st.stageRd1;
      next_st.flagRd1 = st.flags;
      next_st.flagRd2 = st.flagRd1;
      next_st.psr = 1'b0;
      if (timerTick)
      begin
         next_st.blockMatch = 1'b0;
      end
      // counting; clear at top; stopped when select zero
      if (timerTick && effClkSel != fpt_pkg::CS_STOP)
      begin
         if (st.counter == effCmp[fpt_pkg::UNIT_TOP])
         begin
            next_st.counter = fpt_pkg::CNT_RST;
         end
         else
         begin
            next_st.counter = st.counter + fpt_pkg::CNT_ONE;
         end
      end
      // register writes and read side effects
      if (done && !st.err && pwrite)
      begin
         if (isLow)
         begin
            // msbs loaded from stage; shared stage
            if (paddr == fpt_pkg::ADDR_COUNTER)
            begin
               next_st.counter = {st.stage, wByte};
               next_st.blockMatch = 1'b1;
            end
            else
            begin
               next_st.cmp[unitIdx] = {st.stage, wByte};
            end
         end
         else if (paddr == fpt_pkg::ADDR_STAGE)
         begin
            next_st.stage = wByte[fpt_pkg::STAGE_W-1:0];
         end
         else if (paddr == fpt_pkg::ADDR_CTRL_B)
         begin
            next_st.clkSel = wByte[fpt_pkg::CS_LSB +: fpt_pkg::CS_W];
            next_st.psr = wByte[fpt_pkg::PSR_BIT];
         end
         else if (paddr == fpt_pkg::ADDR_CTRL_D)
         begin
            next_st.faultEn = wByte[fpt_pkg::FAULT_EN_BIT];
            if (wByte[fpt_pkg::FAULT_FLAG_BIT])
            begin
               next_st.faultFlag = 1'b0;
            end
         end
         else if (paddr == fpt_pkg::ADDR_FLAGS)
         begin
            next_st.flags = st.flags & ~{wByte[fpt_pkg::TF_D_BIT], wByte[fpt_pkg::TF_B_BIT],
               wByte[fpt_pkg::TF_A_BIT], wByte[fpt_pkg::TF_OVF_BIT]};
         end
         else if (paddr == fpt_pkg::ADDR_MASK)
         begin
            next_st.mask = {wByte[fpt_pkg::TF_D_BIT], wByte[fpt_pkg::TF_B_BIT],
               wByte[fpt_pkg::TF_A_BIT], wByte[fpt_pkg::TF_OVF_BIT]};
         end
         else if (paddr == fpt_pkg::ADDR_PLL)
         begin
            next_st.lowSpeed = wByte[fpt_pkg::SLOW_BIT];
            next_st.asyncSel = wByte[fpt_pkg::ASYNC_BIT];
         end
      end
      else if (done && !st.err && isLow)
      begin
         // low read copies msbs; overwrites stage
         next_st.stage = lowReg[fpt_pkg::CNT_W-1 -: fpt_pkg::STAGE_W];
      end
      // event flags, set wins over clear
      if (timerTick && effClkSel != fpt_pkg::CS_STOP
         && st.counter == effCmp[fpt_pkg::UNIT_TOP])
      begin
         next_st.flags[fpt_pkg::FL_OVF] = 1'b1;
      end
      if (matchPulse[fpt_pkg::UNIT_A])
      begin
         next_st.flags[fpt_pkg::FL_A] = 1'b1;
      end
      if (matchPulse[fpt_pkg::UNIT_B])
      begin
         next_st.flags[fpt_pkg::FL_B] = 1'b1;
      end
      if (matchPulse[fpt_pkg::UNIT_D])
      begin
         next_st.flags[fpt_pkg::FL_D] = 1'b1;
      end
      if (faultEvent)
      begin
         next_st.faultFlag = 1'b1;
      end
      next_st.irq = {st.faultFlag && st.faultEn, st.flags & st.mask};
      next_st.bottom = (st.counter == fpt_pkg::CNT_RST);
      next_st.max = (st.counter[fpt_pkg::LOW_W-1:0] == fpt_pkg::MAX8);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st <= '0;
         st.cmp[fpt_pkg::UNIT_TOP] <= fpt_pkg::TOP_RST;
         st.cmpSync1[fpt_pkg::UNIT_TOP] <= fpt_pkg::TOP_RST;
         st.cmpSync2[fpt_pkg::UNIT_TOP] <= fpt_pkg::TOP_RST;
      end
      else if (clkEn)
      begin
         st <= next_st;
      end
   end

   // ************
   // outputs
   // ************
   assign pready = st.ready;
   assign prdata = st.rdata;
   assign pslverr = st.err;
   assign pwmA = unitPin[fpt_pkg::UNIT_A];
   assign pwmB = unitPin[fpt_pkg::UNIT_B];
   assign pwmD = unitPin[fpt_pkg::UNIT_D];
   assign irqReq = st.irq;
   assign atBottom = st.bottom;
   assign atMax = st.max;
endmodule : fpt_timer_top
`default_nettype wire

/* testbench/fpt_cpu_model.sv */
// cpu side model: bus master issuing one word transfer at a time
`timescale 1ns/1ps
`default_nettype none
module fpt_cpu_model
(
   input wire logic core_clk,
   input wire logic pready,
   input wire logic [fpt_pkg::DATA_W-1:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [fpt_pkg::ADDR_W-1:0] paddr,
   output logic [fpt_pkg::DATA_W-1:0] pwdata
);
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   task automatic xfer(input logic isWrite, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= isWrite;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
         @(posedge core_clk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : fpt_cpu_model
`default_nettype wire

/* testbench/fpt_timer_checker.sv */
// checker: bus timing, readback shadows and mask relations of the timer
`timescale 1ns/1ps
`default_nettype none
module fpt_timer_checker
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic faultEvent,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fpt_pkg::ADDR_W-1:0] paddr,
   input wire logic [fpt_pkg::DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic [fpt_pkg::DATA_W-1:0] prdata,
   input wire logic pslverr,
   input wire logic [fpt_pkg::IRQ_N-1:0] irqReq,
   input wire logic atBottom,
   input wire logic atMax
);
   // ************
   // shadow state
   // ************
   logic wrDone, rdDone, isCmp, stageOk, faultEn, faultOld, asyncOn;
   logic [1:0] unit, stage;
   logic [9:0] cmp [4];
   logic [3:0] cs, quiet;
   logic [7:0] maskNow, maskOld;
   assign wrDone = psel && penable && pready && pwrite && !pslverr;
   assign rdDone = psel && penable && pready && !pwrite && !pslverr;
   assign isCmp = paddr >= fpt_pkg::ADDR_CMP_A && paddr <= fpt_pkg::ADDR_CMP_D && paddr[1:0] == 2'h0;
   assign unit = 2'(paddr[4:2] - 3'h1);
   always_ff @(posedge core_clk)
   begin
      maskOld <= maskNow;
      faultOld <= faultEn;
      if (sys_rst)
      begin
         stage <= 2'h0;
         stageOk <= 1'b1;
         cmp <= '{10'h000, 10'h000, fpt_pkg::TOP_RST, 10'h000};
         cs <= 4'h0;
         maskNow <= 8'h00;
         faultEn <= 1'b0;
         asyncOn <= 1'b0;
         quiet <= 4'h0;
      end
      else
      begin
         quiet <= wrDone ? 4'h0 : (quiet == 4'hF ? quiet : quiet + 4'h1);
         stageOk <= (wrDone && paddr == fpt_pkg::ADDR_STAGE) ||
            (stageOk && !(rdDone && paddr == fpt_pkg::ADDR_COUNTER));
         if (rdDone && isCmp) stage <= cmp[unit][9:8];
         if (wrDone)
         begin
            case (paddr)
               fpt_pkg::ADDR_STAGE: stage <= pwdata[1:0];
               fpt_pkg::ADDR_CTRL_B: cs <= pwdata[3:0];
               fpt_pkg::ADDR_CTRL_D: faultEn <= pwdata[fpt_pkg::FAULT_EN_BIT];
               fpt_pkg::ADDR_MASK: maskNow <= pwdata[7:0];
               fpt_pkg::ADDR_PLL: asyncOn <= pwdata[fpt_pkg::ASYNC_BIT];
               default: ;
            endcase
            if (isCmp) cmp[unit] <= {stage, pwdata[7:0]};
         end
      end
   end
   // ************
   // assertions
   // ************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence s_answer;
      !pready ##1 pready ##1 !pready;
   endsequence
   a_one_wait: assert property (s_setup |-> s_answer)
      else $error("bus wait wrong");
   a_cmp_back: assert property (
      rdDone && isCmp |-> prdata == {24'h0, cmp[unit][7:0]})
      else $error("compare readback");
   a_stage_back: assert property (
      rdDone && paddr == fpt_pkg::ADDR_STAGE && stageOk && !asyncOn |-> prdata[1:0] == stage)
      else $error("stage readback");
   a_ctrl_back: assert property (
      rdDone && paddr == fpt_pkg::ADDR_CTRL_B |-> !prdata[fpt_pkg::PSR_BIT] && prdata[3:0] == cs)
      else $error("control readback");
   a_stop_holds: assert property (
      cs == 4'h0 && quiet == 4'hF |=> $stable(atBottom) && $stable(atMax))
      else $error("stopped moved");
   a_fault_mask: assert property (
      !faultEn && !faultOld |-> !irqReq[fpt_pkg::IRQ_FAULT])
      else $error("fault unmasked");
   a_fault_raise: assert property (
      faultEvent && faultEn && faultOld |-> ##[1:2] irqReq[fpt_pkg::IRQ_FAULT])
      else $error("fault missing");
   a_mask_a: assert property (
      !maskNow[fpt_pkg::TF_A_BIT] && !maskOld[fpt_pkg::TF_A_BIT] |-> !irqReq[fpt_pkg::FL_A])
      else $error("match a unmasked");
   a_mask_ovf: assert property (
      !maskNow[fpt_pkg::TF_OVF_BIT] && !maskOld[fpt_pkg::TF_OVF_BIT] |-> !irqReq[fpt_pkg::FL_OVF])
      else $error("overflow unmasked");
endmodule : fpt_timer_checker
bind fpt_timer_top fpt_timer_checker u_fpt_timer_checker
(
   .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
   .faultEvent(faultEvent), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .irqReq(irqReq),
   .atBottom(atBottom), .atMax(atMax)
);
`default_nettype wire

/* testbench/test_fast_pwm_timer_clocking_access.sv */
// testbench: register access, counting, prescaler, flags and requests
`timescale 1ns/1ps
`default_nettype none
module test_fast_pwm_timer_clocking_access;
   logic core_clk, sys_rst, clkEn, faultEvent, psel, penable, pwrite;
   logic fastTick = 1'b0;
   logic pready, pslverr, pwmA, pwmB, pwmD, atBottom, atMax, e;
   logic sMax, sBot, sHi, sLo;
   logic [fpt_pkg::ADDR_W-1:0] paddr;
   logic [fpt_pkg::DATA_W-1:0] pwdata, prdata, q;
   logic [fpt_pkg::IRQ_N-1:0] irqReq;
   logic [9:0] v;
   logic [7:0] cAddr [3] = '{fpt_pkg::ADDR_CMP_A, fpt_pkg::ADDR_CMP_B, fpt_pkg::ADDR_CMP_D};
   logic [9:0] cVal [3] = '{10'h2A5, 10'h155, 10'h3C3};
   logic [7:0] tPll [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h84};
   int tCs [6] = '{1, 2, 4, 15, 1, 1};
   int tWait [6] = '{30, 60, 240, 49152, 60, 120};
   int tLo [6] = '{29, 29, 29, 2, 26, 26};
   int tHi [6] = '{42, 38, 34, 4, 36, 36};
   int nErrors = 0;
   int totalChecks = 0;
   fpt_timer_top u_fpt_timer_top
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .fastTick(fastTick),
      .faultEvent(faultEvent), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pwmA(pwmA), .pwmB(pwmB), .pwmD(pwmD), .irqReq(irqReq),
      .atBottom(atBottom), .atMax(atMax)
   );
   fpt_cpu_model u_fpt_cpu_model
   (
      .core_clk(core_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
   );
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // fast tick at half the core rate
   always @(posedge core_clk) fastTick <= !fastTick;
   // ************
   // tasks
   // ************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         nErrors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_fpt_cpu_model.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      u_fpt_cpu_model.xfer(1'b0, a, 32'h0, r, e);
   endtask : rd
   task automatic wr10(input logic [7:0] a, input logic [9:0] d);
      wr(fpt_pkg::ADDR_STAGE, {30'h0, d[9:8]});
      wr(a, {24'h0, d[7:0]});
   endtask : wr10
   task automatic rd10(input logic [7:0] a, output logic [9:0] r);
      logic [31:0] lo;
      logic [31:0] hi;
      rd(a, lo);
      rd(fpt_pkg::ADDR_STAGE, hi);
      r = {hi[1:0], lo[7:0]};
   endtask : rd10
   task automatic watch(input int n);
      {sMax, sBot, sHi, sLo} = 4'h0;
      repeat (n)
      begin
         @(posedge core_clk);
         sMax |= atMax;
         sBot |= atBottom;
         sHi |= pwmA;
         sLo |= !pwmA;
      end
   endtask : watch
   task automatic closeOut();
      $display("checks %0d errors %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : closeOut
   initial
   begin
      repeat (80000) @(posedge core_clk);
      nErrors++;
      closeOut();
   end
   // ************
   // main sequence
   // ************
   initial
   begin
      sys_rst = 1'b1;
      clkEn = 1'b1;
      faultEvent = 1'b0;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd10(fpt_pkg::ADDR_CMP_TOP, v);
      chk({22'h0, v}, 32'h3FF);
      for (int i = 0; i < 3; i++)
      begin
         wr10(cAddr[i], cVal[i]);
         rd10(cAddr[i], v);
         chk({22'h0, v}, {22'h0, cVal[i]});
      end
      rd(fpt_pkg::ADDR_CMP_A, q);
      rd(fpt_pkg::ADDR_CMP_B, q);
      rd(fpt_pkg::ADDR_STAGE, q);
      chk(q & 32'h3, 32'h1);
      wr(fpt_pkg::ADDR_STAGE, 32'h3);
      wr(fpt_pkg::ADDR_CMP_D, 32'h11);
      wr(fpt_pkg::ADDR_CMP_A, 32'h22);
      rd10(fpt_pkg::ADDR_CMP_D, v);
      chk({22'h0, v}, 32'h311);
      rd10(fpt_pkg::ADDR_CMP_A, v);
      chk({22'h0, v}, 32'h322);
      wr10(fpt_pkg::ADDR_CMP_B, 10'h0AB);
      rd10(fpt_pkg::ADDR_CMP_B, v);
      chk({22'h0, v}, 32'h0AB);
      wr(fpt_pkg::ADDR_CTRL_B, 32'h0);
      wr10(fpt_pkg::ADDR_COUNTER, 10'h237);
      repeat (40) @(posedge core_clk);
      rd10(fpt_pkg::ADDR_COUNTER, v);
      chk({22'h0, v}, 32'h237);
      u_fpt_cpu_model.xfer(1'b0, 8'h30, 32'h0, q, e);
      chk({q[30:0], e}, 32'h1);
      for (int i = 0; i < 6; i++)
      begin
         wr(fpt_pkg::ADDR_PLL, {24'h0, tPll[i]});
         wr(fpt_pkg::ADDR_CTRL_B, 32'h40 | 32'(tCs[i]));
         wr10(fpt_pkg::ADDR_COUNTER, 10'h000);
         repeat (tWait[i]) @(posedge core_clk);
         rd(fpt_pkg::ADDR_COUNTER, q);
         chk({31'h0, q[7:0] >= tLo[i] && q[7:0] <= tHi[i]}, 32'h1);
      end
      wr(fpt_pkg::ADDR_PLL, 32'h0);
      wr(fpt_pkg::ADDR_CTRL_B, 32'h1);
      watch(1100);
      chk({30'h0, sMax, sBot}, 32'h3);
      wr(fpt_pkg::ADDR_CTRL_D, 32'h80);
      faultEvent <= 1'b1;
      @(posedge core_clk);
      faultEvent <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk({31'h0, irqReq[fpt_pkg::IRQ_FAULT]}, 32'h1);
      rd(fpt_pkg::ADDR_CTRL_D, q);
      chk(q, 32'hC0);
      wr(fpt_pkg::ADDR_CTRL_D, 32'hC0);
      rd(fpt_pkg::ADDR_CTRL_D, q);
      chk(q, 32'h80);
      wr10(fpt_pkg::ADDR_CMP_TOP, 10'h00F);
      wr10(fpt_pkg::ADDR_COUNTER, 10'h000);
      wr(fpt_pkg::ADDR_FLAGS, 32'hE4);
      wr10(fpt_pkg::ADDR_CMP_A, 10'h005);
      wr(fpt_pkg::ADDR_MASK, 32'h44);
      watch(60);
      chk({30'h0, sHi, sLo}, 32'h3);
      chk({30'h0, irqReq[fpt_pkg::FL_A], irqReq[fpt_pkg::FL_OVF]}, 32'h3);
      rd(fpt_pkg::ADDR_FLAGS, q);
      chk(q & 32'hE4, 32'h44);
      rd(fpt_pkg::ADDR_COUNTER, q);
      chk({31'h0, q[7:0] <= 8'h0F}, 32'h1);
      wr(fpt_pkg::ADDR_MASK, 32'h0);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irqReq[fpt_pkg::FL_A]}, 32'h0);
      closeOut();
   end
endmodule : test_fast_pwm_timer_clocking_access
`default_nettype wire
